//--- pkg/smbus_pkg.sv
/*
  Shared constants and types for the two-wire management bus slave port and
  the host master that drives it. Assumes both ends compile against it.
*/
package smbus_pkg;

  // Slave addressing
  localparam logic [4:0]  SLAVE_ADDR_HI   = 5'h0B;
  localparam int          EVENT_W         = 8;

  // Command and address space
  localparam logic [7:0]  CMD_BLOCK_WRITE = 8'hA0;
  localparam logic [7:0]  RAM_LAST        = 8'h6F;
  localparam int          RAM_DEPTH       = 112;
  localparam logic [7:0]  EE_HI_FIRST     = 8'h80;
  localparam logic [7:0]  EE_HI_LAST      = 8'h9F;
  localparam int          EE_AW           = 13;
  localparam int          EE_PAGE_BITS    = 6;
  localparam logic [7:0]  EE_BLANK        = 8'hFF;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
  localparam int          PTR_EE_BIT      = 15;

  // Volatile control registers
  localparam logic [7:0]  MODE_REG_ADDR   = 8'h13;
  localparam logic [7:0]  STATUS_REG_ADDR = 8'h41;
  localparam logic [7:0]  MASK_REG_ADDR   = 8'h42;
  localparam logic [2:0]  MODE_READ       = 3'h1;
  localparam logic [2:0]  MODE_PROGRAM    = 3'h2;
  localparam logic [2:0]  MODE_ERASE      = 3'h4;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  MASK_RESET      = 8'hFF;

  // Byte framing
  localparam logic [3:0]  BYTE_BITS       = 4'h8;

  // Host bus timing
  localparam int          CLK_MHZ         = 40;
  localparam int          T_LOW_NS        = 4700;
  localparam int          T_HIGH_NS       = 4000;
  localparam int          T_HD_STA_NS     = 4000;
  localparam int          T_BUF_NS        = 4700;
  localparam int          T_HD_DAT_NS     = 300;
  localparam int          T_LOW_CYC       = (T_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_HIGH_CYC      = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_HD_STA_CYC    = (T_HD_STA_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_BUF_CYC       = (T_BUF_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_HD_DAT_CYC    = (T_HD_DAT_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W           = 9;

  // Device bus engine states
  typedef enum logic [5:0] {
    D_IDLE  = 6'h01,
    D_ADDR  = 6'h02,
    D_ACK   = 6'h04,
    D_WDATA = 6'h08,
    D_RDATA = 6'h10,
    D_RACK  = 6'h20
  } dev_state_t;

  // Host engine states
  typedef enum logic [9:0] {
    H_IDLE    = 10'h001,
    H_HOLD    = 10'h002,
    H_RS_LOW  = 10'h004,
    H_START_A = 10'h008,
    H_START_B = 10'h010,
    H_BIT_LOW = 10'h020,
    H_BIT_HI  = 10'h040,
    H_STOP_A  = 10'h080,
    H_STOP_B  = 10'h100,
    H_STOP_C  = 10'h200
  } host_state_t;

  // Host command kinds
  typedef enum logic [2:0] {
    HC_START     = 3'h0,
    HC_WRITE     = 3'h1,
    HC_READ_ACK  = 3'h2,
    HC_READ_NACK = 3'h3,
    HC_STOP      = 3'h4
  } host_cmd_t;

endpackage

//--- pkg/smbus_if.sv
/*
  Two-wire bus between host master and device slave, open drain on both
  lines. Each driver gives an output and an enable; the wire is pulled high.
*/
`timescale 1ns/10ps
`default_nettype none
interface smbus_if;
  // Drivers
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // Resolved wire levels, pulled up when nobody drives
  logic scl;
  logic sda;

  // Wired-and resolution
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host   (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport device (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

//--- verilog/smbus_host_end.sv
/*
  Host master: turns start, byte and stop commands into bus waveforms,
  making the serial clock from the system clock by a counter.
  Assumes a single slave with no clock stretching.
*/
`timescale 1ns/10ps
`default_nettype none
module smbus_host_end (
  // System clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Bus
  smbus_if.host                      bus,
  // Command port
  input  wire logic                  cmd_valid,
  input  wire smbus_pkg::host_cmd_t  cmd_kind,
  input  wire logic [7:0]            cmd_data,
  output var  logic                  cmd_ready,
  // Answer port
  output var  logic                  rsp_valid,
  output var  logic [7:0]            rsp_data,
  output var  logic                  rsp_nack
);
  import smbus_pkg::*;

  typedef struct packed {
    host_state_t       st;
    logic [CNT_W-1:0]  cnt;
    logic              pend;
    logic              scl_oe;
    logic              sda_oe;
    logic [8:0]        tx;
    logic [8:0]        rx;
    logic [3:0]        bitn;
    logic              sda_s1;
    logic              sda_s2;
    logic              ready;
    logic              rsp_valid;
    logic [7:0]        rsp_data;
    logic              rsp_nack;
  } host_regs_t;

  host_regs_t q_r;
  host_regs_t q_nxt;

  function automatic logic hit(input logic [CNT_W-1:0] c, input int lim);
    hit = (c == CNT_W'(lim - 1));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state; data moves only a hold time after the clock fell
  always_comb begin
    q_nxt           = q_r;
    q_nxt.rsp_valid = 1'b0;
    q_nxt.sda_s1    = bus.sda;
    q_nxt.sda_s2    = q_r.sda_s1;
    q_nxt.cnt       = q_r.cnt + CNT_W'(1);
    if ((q_r.st == H_BIT_LOW || q_r.st == H_RS_LOW || q_r.st == H_STOP_A) &&
        q_r.cnt == CNT_W'(T_HD_DAT_CYC)) begin
      q_nxt.sda_oe = ~q_r.pend;
    end
    unique case (q_r.st)
      H_IDLE, H_HOLD: begin
        q_nxt.cnt = '0;
        if (cmd_valid && q_r.ready) begin
          q_nxt.ready = 1'b0;
          q_nxt.bitn  = '0;
          unique case (cmd_kind)
            HC_START: begin
              // From mid-transfer this becomes a repeated start
              q_nxt.pend = 1'b1;
              q_nxt.st   = (q_r.st == H_IDLE) ? H_START_A : H_RS_LOW;
            end
            HC_WRITE: begin
              q_nxt.tx   = {cmd_data, 1'b1};
              q_nxt.pend = cmd_data[7];
              q_nxt.st   = H_BIT_LOW;
            end
            HC_READ_ACK, HC_READ_NACK: begin
              // A last read is left unacknowledged
              q_nxt.tx   = {8'hFF, (cmd_kind == HC_READ_NACK)};
              q_nxt.pend = 1'b1;
              q_nxt.st   = H_BIT_LOW;
            end
            default: begin
              q_nxt.pend = 1'b0;
              q_nxt.st   = H_STOP_A;
            end
          endcase
        end
      end
      H_RS_LOW: if (hit(q_r.cnt, T_LOW_CYC)) begin
        q_nxt.scl_oe = 1'b0;
        q_nxt.cnt    = '0;
        q_nxt.st     = H_START_A;
      end
      H_START_A: if (hit(q_r.cnt, T_BUF_CYC)) begin
        q_nxt.sda_oe = 1'b1;
        q_nxt.cnt    = '0;
        q_nxt.st     = H_START_B;
      end
      H_START_B: if (hit(q_r.cnt, T_HD_STA_CYC)) begin
        q_nxt.scl_oe    = 1'b1;
        q_nxt.st        = H_HOLD;
        q_nxt.ready     = 1'b1;
        q_nxt.rsp_valid = 1'b1;
      end
      H_BIT_LOW: if (hit(q_r.cnt, T_LOW_CYC)) begin
        q_nxt.scl_oe = 1'b0;
        q_nxt.cnt    = '0;
        q_nxt.st     = H_BIT_HI;
      end
      H_BIT_HI: if (hit(q_r.cnt, T_HIGH_CYC)) begin
        q_nxt.rx     = {q_r.rx[7:0], q_r.sda_s2};
        q_nxt.scl_oe = 1'b1;
        q_nxt.cnt    = '0;
        if (q_r.bitn == BYTE_BITS) begin
          q_nxt.st        = H_HOLD;
          q_nxt.ready     = 1'b1;
          q_nxt.rsp_valid = 1'b1;
          q_nxt.rsp_data  = q_r.rx[7:0];
          q_nxt.rsp_nack  = q_r.sda_s2;
        end else begin
          q_nxt.bitn = q_r.bitn + 4'h1;
          q_nxt.tx   = {q_r.tx[7:0], 1'b1};
          q_nxt.pend = q_r.tx[7];
          q_nxt.st   = H_BIT_LOW;
        end
      end
      H_STOP_A: if (hit(q_r.cnt, T_LOW_CYC)) begin
        q_nxt.scl_oe = 1'b0;
        q_nxt.cnt    = '0;
        q_nxt.st     = H_STOP_B;
      end
      H_STOP_B: if (hit(q_r.cnt, T_HIGH_CYC)) begin
        q_nxt.sda_oe = 1'b0;
        q_nxt.cnt    = '0;
        q_nxt.st     = H_STOP_C;
      end
      H_STOP_C: if (hit(q_r.cnt, T_BUF_CYC)) begin
        q_nxt.st        = H_IDLE;
        q_nxt.ready     = 1'b1;
        q_nxt.rsp_valid = 1'b1;
      end
      default: q_nxt.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= '{st: H_IDLE, ready: 1'b1, tx: 9'h1FF, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs; lines are only ever pulled low
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = q_r.scl_oe;
  assign bus.host_sda_oe = q_r.sda_oe;
  assign cmd_ready       = q_r.ready;
  assign rsp_valid       = q_r.rsp_valid;
  assign rsp_data        = q_r.rsp_data;
  assign rsp_nack        = q_r.rsp_nack;
endmodule // smbus_host_end
`default_nettype wire

//--- verilog/smbus_device_end.sv
/*
  Device slave port: bus engine, address pointer, volatile registers and
  nonvolatile store. Runs on the link clock, oversampling both lines.
  Assumes the link clock is many times faster than the serial clock.
*/
// Functional notes
// - Slave only, address top five bits 01011
// - Strap gives low bits: gnd 00, open 10, vcc 01
// - Open strap answers to 0101110
// - Strap latched at first start, then locked
// - First written byte loads address pointer, except command A0h
// - Start is data falling while clock high
// - Address MSB first, then direction bit
// - Matching slave pulls data low for ninth clock, except reads of the store outside read mode
// - Mismatch stays idle, never drives data
// - Each byte is eight bits plus acknowledge
// - Data changes only while clock low
// - First write byte is command or address
// - Master writes pointer before reads
// - Master ends write with stop
// - Read ends with master not acknowledging
// - Repeated start begins fresh transaction
// - Nonvolatile store at 8000h to 9FFFh
// - Nonvolatile byte written only when blank
// - Status latches events, mask gates alert
// - Volatile registers at 00h to 6Fh
// - Mode register bits select read, program, erase
// - Command A0h announces block write
`timescale 1ns/10ps
`default_nettype none
module smbus_device_end #(
  parameter int EE_DEPTH = 8192
) (
  // Link clock and reset
  input  wire logic                          link_clock,
  input  wire logic                          rst,
  // Bus
  smbus_if.device                            bus,
  // Address strap pad sensing
  input  wire logic                          strap_pulled_high,
  input  wire logic                          strap_pulled_low,
  // Limit events and alert
  input  wire logic [smbus_pkg::EVENT_W-1:0] limit_event,
  output var  logic                          alert
);
  import smbus_pkg::*;

  typedef struct packed {
    logic               scl_s1;
    logic               scl_s2;
    logic               scl_q;
    logic               sda_s1;
    logic               sda_s2;
    logic               sda_q;
    logic               hi_s1;
    logic               hi_s2;
    logic               lo_s1;
    logic               lo_s2;
    logic [EVENT_W-1:0] ev_s1;
    logic [EVENT_W-1:0] ev_s2;
    logic               locked;
    logic               strap_address_bit_one;
    logic               strap_address_bit_zero;
    dev_state_t         st;
    logic [3:0]         bitcnt;
    logic [7:0]         shreg;
    logic               rw;
    logic [1:0]         idx;
    logic               blk;
    logic               ee_hi;
    logic [15:0]        ptr;
    logic [7:0]         mode;
    logic [EVENT_W-1:0] status;
    logic [EVENT_W-1:0] mask;
    logic               sda_oe;
    logic               alert;
  } dev_regs_t;

  dev_regs_t   q_r;
  dev_regs_t   q_nxt;

  // Storage arrays, not reset: the nonvolatile one survives rst
  logic [7:0]  ram_mem [RAM_DEPTH];
  logic [7:0]  ee_mem  [EE_DEPTH];

  // Write strobes from the engine
  logic        ram_we;
  logic        ee_we;
  logic        ee_erase;
  logic [15:0] wr_ptr;
  logic [7:0]  wr_data;

  // Decoded bus events
  logic        start_ev;
  logic        stop_ev;
  logic        rise_ev;
  logic        fall_ev;
  logic [7:0]  rd_byte;
  logic [6:0]  own_addr;
  logic        ack;
  logic        data_phase;
  logic        ee_blank;

  ////////////////////////////////////////////////////////////////////////
  // Edge and condition detection on the second and third sample stages
  assign start_ev = q_r.scl_s2 & q_r.scl_q & q_r.sda_q & ~q_r.sda_s2;
  assign stop_ev  = q_r.scl_s2 & q_r.scl_q & ~q_r.sda_q & q_r.sda_s2;
  assign rise_ev  = q_r.scl_s2 & ~q_r.scl_q;
  assign fall_ev  = ~q_r.scl_s2 & q_r.scl_q;

  // Own address: fixed high part and locked strap bits
  assign own_addr = {SLAVE_ADDR_HI, q_r.strap_address_bit_one,
                     q_r.strap_address_bit_zero};

  assign ee_blank = (ee_mem[q_r.ptr[EE_AW-1:0]] == EE_BLANK);

  // Read path: store, then control registers, then volatile array
  always_comb begin
    rd_byte = UNMAPPED_DATA;
    if (q_r.ptr[PTR_EE_BIT]) begin
      rd_byte = ee_mem[q_r.ptr[EE_AW-1:0]];
    end else if (q_r.ptr[15:8] == 8'h00 && q_r.ptr[7:0] <= RAM_LAST) begin
      if (q_r.ptr[7:0] == MODE_REG_ADDR) begin
        rd_byte = q_r.mode;
      end else if (q_r.ptr[7:0] == STATUS_REG_ADDR) begin
        rd_byte = q_r.status;
      end else if (q_r.ptr[7:0] == MASK_REG_ADDR) begin
        rd_byte = q_r.mask;
      end else begin
        rd_byte = ram_mem[q_r.ptr[6:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus engine and register side effects
  always_comb begin
    q_nxt       = q_r;
    ram_we      = 1'b0;
    ee_we       = 1'b0;
    ee_erase    = 1'b0;
    wr_ptr      = q_r.ptr;
    wr_data     = q_r.shreg;
    ack         = 1'b0;
    data_phase  = 1'b0;
    // Two-stage synchronisers on every pin
    q_nxt.scl_s1 = bus.scl;
    q_nxt.scl_s2 = q_r.scl_s1;
    q_nxt.scl_q  = q_r.scl_s2;
    q_nxt.sda_s1 = bus.sda;
    q_nxt.sda_s2 = q_r.sda_s1;
    q_nxt.sda_q  = q_r.sda_s2;
    q_nxt.hi_s1  = strap_pulled_high;
    q_nxt.hi_s2  = q_r.hi_s1;
    q_nxt.lo_s1  = strap_pulled_low;
    q_nxt.lo_s2  = q_r.lo_s1;
    q_nxt.ev_s1  = limit_event;
    q_nxt.ev_s2  = q_r.ev_s1;
    // New events win over a clear in the same cycle
    q_nxt.status = q_r.status | q_r.ev_s2;

    if (start_ev) begin
      // A start mid-transfer is a repeated start: the frame restarts, pointer and registers are kept
      q_nxt.st     = D_ADDR;
      q_nxt.bitcnt = '0;
      q_nxt.idx    = '0;
      q_nxt.blk    = 1'b0;
      q_nxt.ee_hi  = 1'b0;
      q_nxt.sda_oe = 1'b0;
      if (!q_r.locked) begin
        q_nxt.locked                 = 1'b1;
        q_nxt.strap_address_bit_one  = ~q_r.hi_s2 & ~q_r.lo_s2;
        q_nxt.strap_address_bit_zero = q_r.hi_s2;
      end
    end else if (stop_ev) begin
      q_nxt.st     = D_IDLE;
      q_nxt.sda_oe = 1'b0;
    end else if (rise_ev) begin
      unique case (q_r.st)
        D_ADDR, D_WDATA: begin
          q_nxt.shreg  = {q_r.shreg[6:0], q_r.sda_s2};
          q_nxt.bitcnt = q_r.bitcnt + 4'h1;
        end
        D_RDATA: q_nxt.bitcnt = q_r.bitcnt + 4'h1;
        D_RACK: if (q_r.sda_s2) begin
          q_nxt.st = D_IDLE;
        end
        default: ;
      endcase
    end else if (fall_ev) begin
      unique case (q_r.st)
        D_ADDR: if (q_r.bitcnt == BYTE_BITS) begin
          q_nxt.rw = q_r.shreg[0];
          // Reads of the store need read mode selected
          ack = (q_r.shreg[7:1] == own_addr) &&
                (!q_r.shreg[0] || !q_r.ptr[PTR_EE_BIT] ||
                 q_r.mode[2:0] == MODE_READ);
          q_nxt.sda_oe = ack;
          q_nxt.st     = ack ? D_ACK : D_IDLE;
        end
        D_WDATA: if (q_r.bitcnt == BYTE_BITS) begin
          ack = 1'b1;
          if (q_r.idx == 2'd0) begin
            if (q_r.shreg == CMD_BLOCK_WRITE) begin
              q_nxt.blk = 1'b1;
            end else if (q_r.shreg >= EE_HI_FIRST && q_r.shreg <= EE_HI_LAST) begin
              q_nxt.ee_hi = 1'b1;
              q_nxt.ptr   = {q_r.shreg, 8'h00};
            end else begin
              q_nxt.ptr = {8'h00, q_r.shreg};
            end
          end else if (q_r.idx == 2'd1 && q_r.ee_hi) begin
            q_nxt.ptr[7:0] = q_r.shreg;
          end else if (q_r.idx == 2'd1 && q_r.blk) begin
            ack = 1'b1;  // Byte count; the block simply runs on
          end else begin
            data_phase = 1'b1;
          end
          if (data_phase && q_r.ptr[PTR_EE_BIT]) begin
            if (q_r.mode[2:0] == MODE_ERASE && !q_r.blk) begin
              ee_erase = 1'b1;
            end else if (q_r.mode[2:0] == MODE_PROGRAM && ee_blank) begin
              ee_we     = 1'b1;
              q_nxt.ptr = q_r.ptr + 16'h0001;
            end else begin
              ack = 1'b0;
            end
          end else if (data_phase) begin
            q_nxt.ptr = q_r.ptr + 16'h0001;
            if (q_r.ptr[7:0] == MODE_REG_ADDR) begin
              q_nxt.mode = q_r.shreg;
            end else if (q_r.ptr[7:0] == STATUS_REG_ADDR) begin
              q_nxt.status = (q_r.status & ~q_r.shreg) | q_r.ev_s2;
            end else if (q_r.ptr[7:0] == MASK_REG_ADDR) begin
              q_nxt.mask = q_r.shreg;
            end else if (q_r.ptr[15:8] == 8'h00 && q_r.ptr[7:0] <= RAM_LAST) begin
              ram_we = 1'b1;
            end
          end
          if (q_r.idx != 2'd3) begin
            q_nxt.idx = q_r.idx + 2'd1;
          end
          q_nxt.sda_oe = ack;
          q_nxt.st     = ack ? D_ACK : D_IDLE;
        end
        D_ACK, D_RACK: begin
          q_nxt.bitcnt = '0;
          q_nxt.sda_oe = 1'b0;
          if (q_r.rw) begin
            // Drive the first bit just after the clock fell
            q_nxt.shreg  = rd_byte;
            q_nxt.sda_oe = ~rd_byte[7];
            q_nxt.ptr    = q_r.ptr + 16'h0001;
            q_nxt.st     = D_RDATA;
          end else begin
            q_nxt.st = D_WDATA;
          end
        end
        D_RDATA: begin
          if (q_r.bitcnt == BYTE_BITS) begin
            q_nxt.sda_oe = 1'b0;
            q_nxt.st     = D_RACK;
          end else begin
            q_nxt.shreg  = {q_r.shreg[6:0], 1'b0};
            q_nxt.sda_oe = ~q_r.shreg[6];
          end
        end
        default: ;
      endcase
    end
    q_nxt.alert = |(q_nxt.status & ~q_nxt.mask);
  end

  // State register
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      q_r <= '{st: D_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1,
               sda_s1: 1'b1, sda_s2: 1'b1, sda_q: 1'b1,
               mode: MODE_RESET, mask: MASK_RESET, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Store starts blank; a page erase clears all bytes of the page at once
  initial begin
    for (int i = 0; i < EE_DEPTH; i++) begin
      ee_mem[i] = EE_BLANK;
    end
  end

  // Array writes; a plain always, since the blank fill at time zero also writes the store
  always @(posedge link_clock) begin
    if (ram_we) begin
      ram_mem[wr_ptr[6:0]] <= wr_data;
    end
    if (ee_we) begin
      ee_mem[wr_ptr[EE_AW-1:0]] <= wr_data;
    end
    if (ee_erase) begin
      for (int j = 0; j < (1 << EE_PAGE_BITS); j++) begin
        ee_mem[{wr_ptr[EE_AW-1:EE_PAGE_BITS], EE_PAGE_BITS'(j)}] <= EE_BLANK;
      end
    end
  end

  // Outputs: data line only ever pulled low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = q_r.sda_oe;
  assign alert          = q_r.alert;
endmodule // smbus_device_end
`default_nettype wire

//--- dv/smbus_slave_register_port_asserts.sv
/* Checker on the shared bus wires and drivers.
   Assumes it is placed beside the interface joining both ends. */
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_register_port_asserts (
  // Clocks and reset
  input wire logic clock,
  input wire logic link_clock,
  input wire logic rst,
  // Drivers and resolved wires
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import smbus_pkg::*;
  logic [8:0] hi_cnt_r;   // Saturates, idle highs run long
  logic [7:0] rise_cnt_r; // Clock rises since start or stop
  logic       scl_q_r;
  logic       sda_q_r;
  ////////////////////////////////////////////////////////////
  // Track high time and pulses per frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt_r   <= 9'h000;
      rise_cnt_r <= 8'h00;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else begin
      scl_q_r  <= scl;
      sda_q_r  <= sda;
      hi_cnt_r <= !scl ? 9'h000 : (&hi_cnt_r) ? hi_cnt_r : hi_cnt_r + 9'h001;
      if (scl && scl_q_r && sda != sda_q_r)
        rise_cnt_r <= 8'h00;
      else if (scl && !scl_q_r)
        rise_cnt_r <= rise_cnt_r + 8'h01;
    end
  end
  // A start is data falling with the clock high
  sequence start_s;
    scl && scl_q_r && $fell(sda);
  endsequence
  // One full clock pulse seen from the low phase
  sequence pulse_s;
    ##[0:40] scl ##[1:40] !scl;
  endsequence
  scl_od_a: assert property (@(posedge clock) disable iff (rst)
    host_scl_oe |-> !host_scl_o) else $error("host scl not open drain");
  sda_od_a: assert property (@(posedge clock) disable iff (rst)
    host_sda_oe |-> !host_sda_o) else $error("host sda not open drain");
  dev_od_a: assert property (@(posedge link_clock) disable iff (rst)
    dev_sda_oe |-> !dev_sda_o) else $error("device sda not open drain");
  dev_change_a: assert property (@(posedge link_clock) disable iff (rst)
    $changed(dev_sda_oe) |-> !scl) else $error("device data moved in clock high");
  ack_hold_a: assert property (@(posedge link_clock) disable iff (rst)
    $rose(dev_sda_oe) |-> dev_sda_oe throughout pulse_s) else $error("drive dropped early");
  start_hold_a: assert property (@(posedge clock) disable iff (rst)
    start_s |-> scl [*8]) else $error("start hold too short");
  frame_count_a: assert property (@(posedge clock) disable iff (rst)
    scl && scl_q_r && sda != sda_q_r |-> rise_cnt_r == 8'h00 || rise_cnt_r % 9 == 1)
    else $error("frame not nine pulses per byte");
  high_time_a: assert property (@(posedge clock) disable iff (rst)
    $fell(scl) |-> hi_cnt_r >= T_HIGH_CYC) else $error("clock high too short");
endmodule // smbus_slave_register_port_asserts
`default_nettype wire

//--- dv/test_smbus_slave_register_port.sv
/* Bench: host and device ends on one bus, driven by host commands.
   Assumes package, interface, both ends and checker compile first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_smbus_slave_register_port;
  import smbus_pkg::*;
  logic        clock, link_clock, rst, cmd_valid, cmd_ready, rsp_valid, rsp_nack;
  logic        alert, strap_pulled_high, strap_pulled_low;
  host_cmd_t   cmd_kind;
  logic [7:0]  cmd_data, rsp_data, limit_event, h, lo, d;
  logic [6:0]  a;
  logic [31:0] r;
  int          err_total, compares, seed, s;
  smbus_if bus ();
  smbus_host_end u_smbus_host_end (.clock(clock), .rst(rst), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  smbus_device_end u_smbus_device_end (.link_clock(link_clock), .rst(rst), .bus(bus),
    .strap_pulled_high(strap_pulled_high), .strap_pulled_low(strap_pulled_low),
    .limit_event(limit_event), .alert(alert));
  smbus_slave_register_port_asserts u_asserts (.clock(clock), .link_clock(link_clock),
    .rst(rst), .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
    .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
    .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
  ////////////////////////////////////////////////////////////
  // One host command; waits bounded for its answer pulse
  task automatic op(input host_cmd_t k, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_data  <= v;
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    `CHK("done", 1'b1, rsp_valid)
    `CHK("ready", 1'b1, cmd_ready)
  endtask
  task automatic wb(input logic [7:0] v, input logic e);
    op(HC_WRITE, v);
    `CHK("nack", e, rsp_nack)
    `CHK("echo", v, rsp_data)
  endtask
  // Write transaction: command byte then up to two more
  task automatic wr(input logic [7:0] b0, b1, b2, input int n, input logic e2);
    op(HC_START, 8'h00);
    wb({a, 1'b0}, 1'b0);
    wb(b0, 1'b0);
    if (n > 1) wb(b1, 1'b0);
    if (n > 2) wb(b2, e2);
    op(HC_STOP, 8'h00);
  endtask
  // Pointer write, repeated start, one unacknowledged read
  task automatic rd(input logic [7:0] b0, b1, input int n, input logic [7:0] x);
    op(HC_START, 8'h00);
    wb({a, 1'b0}, 1'b0);
    wb(b0, 1'b0);
    if (n > 1) wb(b1, 1'b0);
    op(HC_START, 8'h00);
    wb({a, 1'b1}, 1'b0);
    op(HC_READ_NACK, 8'h00);
    `CHK("data", x, rsp_data)
    op(HC_STOP, 8'h00);
  endtask
  function automatic logic [6:0] exp_addr(input int k);
    return {SLAVE_ADDR_HI, (k == 0) ? 2'b00 : (k == 1) ? 2'b10 : 2'b01};
  endfunction
  task automatic finish_test();
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Clocks unrelated in phase
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #7;
    forever #80 link_clock = ~link_clock;
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (110000) @(posedge clock);
    err_total++;
    finish_test();
  end
  initial begin
    seed = 14702;
    err_total = 0;
    compares = 0;
    link_clock = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = HC_START;
    cmd_data = 8'h00;
    limit_event = 8'h00;
    strap_pulled_high = 1'b0;
    strap_pulled_low = 1'b0;
    // Each strap level: wrong address refused, own address taken
    for (s = 0; s < 3; s++) begin
      @(posedge clock);
      rst <= 1'b1;
      strap_pulled_low <= (s == 0);
      strap_pulled_high <= (s == 1);
      a = exp_addr((s * 2) % 3);
      repeat (3) @(posedge link_clock);
      @(posedge clock);
      rst <= 1'b0;
      repeat (30) @(posedge clock);
      r = $random(seed);
      op(HC_START, 8'h00);
      wb({a ^ (7'h01 << (r[7:0] % 7)), 1'b0}, 1'b1);
      op(HC_START, 8'h00);
      wb({a, 1'b0}, 1'b0);
    end
    op(HC_STOP, 8'h00);
    r = $random(seed);
    h = {3'b100, r[4:0]};
    lo = r[12:5];
    d = {r[21:16], 2'b10};
    // Strap moves after lock; alert source raised but masked
    @(posedge clock) strap_pulled_high <= 1'b1;
    limit_event <= 8'h01 << r[26:24];
    wr(MODE_REG_ADDR, {5'h00, MODE_PROGRAM}, 8'h00, 2, 1'b0);
    wr(h, lo, d, 3, 1'b0);
    wr(h, lo, ~d, 3, 1'b1);
    wr(MODE_REG_ADDR, 8'h00, 8'h00, 1, 1'b0);
    wr(CMD_BLOCK_WRITE, 8'h01, {5'h00, MODE_READ}, 3, 1'b0);
    rd(h, lo, 2, d);
    `CHK("alert", 1'b0, alert)
    wr(MASK_REG_ADDR, ~(8'h01 << r[26:24]), 8'h00, 2, 1'b0);
    `CHK("alert", 1'b1, alert)
    finish_test();
  end
endmodule // test_smbus_slave_register_port
`default_nettype wire
